// ---- rtl/adc_ctrl_pkg.sv ----
package adc_ctrl_pkg;
  // Register byte offsets
  localparam logic [3:0] CTRL_ONE_ADDR = 4'h0;
  localparam logic [3:0] CTRL_TWO_ADDR = 4'h4;
  localparam logic [3:0] RESULT_ADDR = 4'h8;
  // Control one field positions
  localparam int ON_BIT = 15;
  localparam int STOP_IDLE_BIT = 13;
  localparam int FORMAT_LSB = 8;
  localparam int TRIGGER_LSB = 5;
  localparam int STOP_AFTER_IRQ_BIT = 4;
  localparam int AUTO_START_BIT = 2;
  localparam int SAMPLE_BIT_POS = 1;
  localparam int DONE_BIT = 0;
  // Control two field positions
  localparam int REF_SELECT_LSB = 13;
  localparam int OFFSET_CAL_BIT = 12;
  localparam int SCAN_ENABLE_BIT = 10;
  localparam int HALF_STATUS_BIT = 7;
  localparam int SEQ_PER_IRQ_LSB = 2;
  localparam int SPLIT_MODE_BIT = 1;
  localparam int ALT_SAMPLE_BIT = 0;
  // Result formats
  localparam logic [2:0] FMT_INT16 = 3'h0;
  localparam logic [2:0] FMT_SINT16 = 3'h1;
  localparam logic [2:0] FMT_FRAC16 = 3'h2;
  localparam logic [2:0] FMT_SFRAC16 = 3'h3;
  localparam logic [2:0] FMT_INT32 = 3'h4;
  localparam logic [2:0] FMT_SINT32 = 3'h5;
  localparam logic [2:0] FMT_FRAC32 = 3'h6;
  localparam logic [2:0] FMT_SFRAC32 = 3'h7;
  // Trigger sources
  localparam logic [2:0] TRIG_SOFTWARE = 3'h0;
  localparam logic [2:0] TRIG_EXT_EDGE = 3'h1;
  localparam logic [2:0] TRIG_TIMER3 = 3'h2;
  localparam logic [2:0] TRIG_CHARGE = 3'h3;
  localparam logic [2:0] TRIG_AUTO = 3'h7;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Timing of the internal sample counter, result width and slot count
  localparam int CLK_PERIOD_NS = 10;
  localparam int AUTO_SAMPLE_NS = 100;
  localparam int AUTO_SAMPLE_CYCLES = (AUTO_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESULT_BITS = 10;
  localparam int SLOT_COUNT = 16;
  // Sequencer states
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_SAMPLE = 3'b010,
    SEQ_CONVERT = 3'b100
  } seq_state_t;
  // Control one storage
  typedef struct packed {
    logic on;
    logic stop_in_idle;
    logic [2:0] result_format;
    logic [2:0] trigger_source;
    logic stop_after_first_irq;
    logic auto_sample_start;
  } ctrl_one_t;
  // Control two storage
  typedef struct packed {
    logic [2:0] reference_select;
    logic offset_calibration;
    logic input_scan_enable;
    logic [3:0] sequences_per_interrupt;
    logic split_buffer_mode;
    logic alternate_input_sample;
  } ctrl_two_t;
endpackage

// ---- rtl/adc_sample_convert_control.sv ----
`timescale 1ns/100ps
module adc_sample_convert_control #(
  parameter int SAMPLE_CYCLES = adc_ctrl_pkg::AUTO_SAMPLE_CYCLES
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [3:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // System and trigger inputs
  input wire logic device_idle_in,
  input wire logic external_interrupt_zero_in,
  input wire logic timer3_match_in,
  input wire logic charge_time_unit_in,
  // Converter core
  input wire logic convert_done_in,
  input wire logic [adc_ctrl_pkg::RESULT_BITS-1:0] raw_result_in,
  output logic sample_out,
  output logic convert_start_out,
  output logic [31:0] result_word_out,
  output logic [3:0] result_slot_out,
  output logic result_valid_out,
  output logic irq_event_out
);
  import adc_ctrl_pkg::*;

  logic rst_meta_ff, rstn_ff;
  logic ext_s1_ff, ext_s2_ff, ext_s3_ff, ext_level_ff;
  ctrl_one_t c1_ff;
  ctrl_two_t c2_ff;
  seq_state_t state_ff, nxt_state;
  logic done_ff, conv_start_ff, res_valid_ff, irq_ff, half_ff;
  logic [31:0] result_ff;
  logic [3:0] seq_cnt_ff, slot_ff, result_slot_ff;
  logic [15:0] sample_bit_cnt_ff;
  logic aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff;
  logic [3:0] awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic wr_fire, wr_c1, wr_c2, run, halted, ext_edge, end_sample, sw_start, sw_end, seq_done;
  logic irq_now;

  // Result justification; one function covers all eight layouts
  function automatic logic [31:0] justify(input logic [2:0] fmt, input logic [9:0] d);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (fmt)
      FMT_INT16, FMT_INT32: w = {22'h0, d};
      FMT_SINT32: w = {{22{d[9]}}, d};
      FMT_SINT16: w = {16'h0000, {6{d[9]}}, d};
      FMT_FRAC16: w = {16'h0000, d, 6'h00};
      FMT_FRAC32: w = {d, 22'h0};
      FMT_SFRAC16: w = {16'h0000, d, 6'h00};
      FMT_SFRAC32: w = {d, 22'h0};
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // Reset release through two flops so every other flop leaves reset together
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_meta_ff <= 1'b0;
      rstn_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rstn_ff <= rst_meta_ff;
    end
  end

  // External edge pin: three flops, level accepted when the last two agree
  always_ff @(posedge clk_in or negedge rstn_ff) begin
    if (!rstn_ff) begin
      ext_s1_ff <= 1'b0;
      ext_s2_ff <= 1'b0;
      ext_s3_ff <= 1'b0;
      ext_level_ff <= 1'b0;
    end else begin
      ext_s1_ff <= external_interrupt_zero_in;
      ext_s2_ff <= ext_s1_ff;
      ext_s3_ff <= ext_s2_ff;
      if (ext_s2_ff == ext_s3_ff) begin
        ext_level_ff <= ext_s3_ff;
      end
    end
  end
  // Active edge is the filtered rising transition
  assign ext_edge = ext_s2_ff & ext_s3_ff & ~ext_level_ff;

  // AXI write channels are taken independently and joined before the update
  assign s_axi_awready_out = ~aw_got_ff & ~bvalid_ff;
  assign s_axi_wready_out = ~w_got_ff & ~bvalid_ff;
  assign wr_fire = aw_got_ff & w_got_ff & ~bvalid_ff;
  assign wr_c1 = wr_fire && (awaddr_ff == CTRL_ONE_ADDR);
  assign wr_c2 = wr_fire && (awaddr_ff == CTRL_TWO_ADDR);
  always_ff @(posedge clk_in or negedge rstn_ff) begin
    if (!rstn_ff) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 4'h0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= {s_axi_awaddr_in[3:2], 2'b00};
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata_in;
        wstrb_ff <= s_axi_wstrb_in;
      end
      if (wr_fire) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        // The result word is read-only, so writing it is an error too
        bresp_ff <= (wr_c1 || wr_c2) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready_in) begin
        bvalid_ff <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid_out = bvalid_ff;
  assign s_axi_bresp_out = bresp_ff;

  // Software steering of the sample bit, low byte lane only
  assign sw_start = wr_c1 && wstrb_ff[0] && wdata_ff[SAMPLE_BIT_POS]
                    && !c1_ff.auto_sample_start && (state_ff == SEQ_IDLE);
  assign sw_end = wr_c1 && wstrb_ff[0] && !wdata_ff[SAMPLE_BIT_POS];

  // Control one: upper half of the word is not stored at all
  always_ff @(posedge clk_in or negedge rstn_ff) begin
    if (!rstn_ff) begin
      c1_ff <= '0;
    end else begin
      if (irq_now && c1_ff.stop_after_first_irq) begin
        c1_ff.auto_sample_start <= 1'b0;
      end
      if (wr_c1 && wstrb_ff[1]) begin
        c1_ff.on <= wdata_ff[ON_BIT];
        c1_ff.stop_in_idle <= wdata_ff[STOP_IDLE_BIT];
        c1_ff.result_format <= wdata_ff[FORMAT_LSB +: 3];
      end
      // A software write made together with the interrupt takes effect
      if (wr_c1 && wstrb_ff[0]) begin
        c1_ff.trigger_source <= wdata_ff[TRIGGER_LSB +: 3];
        c1_ff.stop_after_first_irq <= wdata_ff[STOP_AFTER_IRQ_BIT];
        c1_ff.auto_sample_start <= wdata_ff[AUTO_START_BIT];
      end
    end
  end

  // Control two: analog fields are only stored and read back; no output port carries them
  always_ff @(posedge clk_in or negedge rstn_ff) begin
    if (!rstn_ff) begin
      c2_ff <= '0;
    end else begin
      if (wr_c2 && wstrb_ff[1]) begin
        c2_ff.reference_select <= wdata_ff[REF_SELECT_LSB +: 3];
        c2_ff.offset_calibration <= wdata_ff[OFFSET_CAL_BIT];
        c2_ff.input_scan_enable <= wdata_ff[SCAN_ENABLE_BIT];
      end
      if (wr_c2 && wstrb_ff[0]) begin
        c2_ff.sequences_per_interrupt <= wdata_ff[SEQ_PER_IRQ_LSB +: 4];
        c2_ff.split_buffer_mode <= wdata_ff[SPLIT_MODE_BIT];
        c2_ff.alternate_input_sample <= wdata_ff[ALT_SAMPLE_BIT];
      end
    end
  end

  // Read path answers one cycle after the address is taken
  assign s_axi_arready_out = ~rvalid_ff;
  always_ff @(posedge clk_in or negedge rstn_ff) begin
    if (!rstn_ff) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= RESP_OKAY;
      if ({s_axi_araddr_in[3:2], 2'b00} == CTRL_ONE_ADDR) begin
        rdata_ff <= {16'h0000, c1_ff.on, 1'b0, c1_ff.stop_in_idle, 2'b00,
                     c1_ff.result_format, c1_ff.trigger_source, c1_ff.stop_after_first_irq,
                     1'b0, c1_ff.auto_sample_start, state_ff == SEQ_SAMPLE, done_ff};
      end else if ({s_axi_araddr_in[3:2], 2'b00} == CTRL_TWO_ADDR) begin
        rdata_ff <= {16'h0000, c2_ff.reference_select, c2_ff.offset_calibration, 1'b0,
                     c2_ff.input_scan_enable, 2'b00, half_ff, 1'b0,
                     c2_ff.sequences_per_interrupt, c2_ff.split_buffer_mode,
                     c2_ff.alternate_input_sample};
      end else if ({s_axi_araddr_in[3:2], 2'b00} == RESULT_ADDR) begin
        rdata_ff <= result_ff;
      end else begin
        rdata_ff <= 32'h0000_0000;
        rresp_ff <= RESP_SLVERR;
      end
    end else if (s_axi_rready_in) begin
      rvalid_ff <= 1'b0;
    end
  end
  assign s_axi_rvalid_out = rvalid_ff;
  assign s_axi_rdata_out = rdata_ff;
  assign s_axi_rresp_out = rresp_ff;

  // Idle with stop-in-idle freezes the sequencer instead of resetting it
  assign halted = c1_ff.stop_in_idle & device_idle_in;
  assign run = c1_ff.on & ~halted;

  // Selected event that ends sampling; reserved codes never fire
  always_comb begin
    case (c1_ff.trigger_source)
      TRIG_SOFTWARE: end_sample = sw_end;
      TRIG_EXT_EDGE: end_sample = ext_edge;
      TRIG_TIMER3: end_sample = timer3_match_in;
      TRIG_CHARGE: end_sample = charge_time_unit_in;
      TRIG_AUTO: end_sample = (sample_bit_cnt_ff == 16'(SAMPLE_CYCLES - 1));
      default: end_sample = 1'b0;
    endcase
  end

  // Sample/convert sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SEQ_IDLE: begin
        if (c1_ff.auto_sample_start || sw_start) begin
          nxt_state = SEQ_SAMPLE;
        end
      end
      SEQ_SAMPLE: begin
        if (end_sample) begin
          nxt_state = SEQ_CONVERT;
        end
      end
      SEQ_CONVERT: begin
        if (convert_done_in) begin
          nxt_state = SEQ_IDLE;
        end
      end
      default: nxt_state = SEQ_IDLE;
    endcase
  end
  assign seq_done = (state_ff == SEQ_CONVERT) && convert_done_in && run;

  always_ff @(posedge clk_in or negedge rstn_ff) begin
    if (!rstn_ff) begin
      state_ff <= SEQ_IDLE;
    end else if (!c1_ff.on) begin
      state_ff <= SEQ_IDLE;
    end else if (run) begin
      state_ff <= nxt_state;
    end
  end

  // Sample timer counts only while sampling
  always_ff @(posedge clk_in or negedge rstn_ff) begin
    if (!rstn_ff) begin
      sample_bit_cnt_ff <= 16'h0000;
    end else if (state_ff != SEQ_SAMPLE || !run) begin
      sample_bit_cnt_ff <= (state_ff == SEQ_SAMPLE) ? sample_bit_cnt_ff : 16'h0000;
    end else if (!end_sample) begin
      sample_bit_cnt_ff <= sample_bit_cnt_ff + 16'h0001;
    end
  end

  // Start pulse to the core and completion flag
  always_ff @(posedge clk_in or negedge rstn_ff) begin
    if (!rstn_ff) begin
      conv_start_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      conv_start_ff <= run && (state_ff == SEQ_SAMPLE) && end_sample;
      if (seq_done) begin
        done_ff <= 1'b1;
      end else if (run && (state_ff == SEQ_SAMPLE) && end_sample) begin
        done_ff <= 1'b0;
      end else if (wr_c1 && wstrb_ff[0] && !wdata_ff[DONE_BIT]) begin
        done_ff <= 1'b0;
      end
    end
  end

  // Sequence counting, interrupt event and buffer slot walk
  assign irq_now = seq_done && (seq_cnt_ff == c2_ff.sequences_per_interrupt);
  always_ff @(posedge clk_in or negedge rstn_ff) begin
    if (!rstn_ff) begin
      seq_cnt_ff <= 4'h0;
      slot_ff <= 4'h0;
      half_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= irq_now;
      if (!c1_ff.on) begin
        seq_cnt_ff <= 4'h0;
        slot_ff <= 4'h0;
        half_ff <= 1'b0;
      end else if (irq_now) begin
        seq_cnt_ff <= 4'h0;
        if (c2_ff.split_buffer_mode) begin
          half_ff <= ~half_ff;
          slot_ff <= {~half_ff, 3'b000};
        end else begin
          slot_ff <= 4'h0;
        end
      end else if (seq_done) begin
        seq_cnt_ff <= seq_cnt_ff + 4'h1;
        slot_ff <= slot_ff + 4'h1;
      end
    end
  end

  // Result word and the slot it belongs to
  always_ff @(posedge clk_in or negedge rstn_ff) begin
    if (!rstn_ff) begin
      result_ff <= 32'h0000_0000;
      result_slot_ff <= 4'h0;
      res_valid_ff <= 1'b0;
    end else begin
      res_valid_ff <= seq_done;
      if (seq_done) begin
        result_ff <= justify(c1_ff.result_format, raw_result_in);
        result_slot_ff <= slot_ff;
      end
    end
  end

  assign sample_out = (state_ff == SEQ_SAMPLE);
  assign convert_start_out = conv_start_ff;
  assign result_word_out = result_ff;
  assign result_slot_out = result_slot_ff;
  assign result_valid_out = res_valid_ff;
  assign irq_event_out = irq_ff;

  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_ff);

  enable_off_idle_a: assert property (!c1_ff.on |=> state_ff == SEQ_IDLE)
    else $error("sequencer active while disabled");
  idle_halt_a: assert property (halted && c1_ff.on |=> $stable(state_ff))
    else $error("sequencer moved while halted in idle");
  done_set_a: assert property (seq_done |=> done_ff && res_valid_ff)
    else $error("completion flag not set after conversion");
  done_clear_a: assert property (conv_start_ff |-> !done_ff)
    else $error("completion flag still set at conversion start");
  int_format_a: assert property (res_valid_ff && $past(c1_ff.result_format) == FMT_INT32
    |-> result_ff[31:10] == 22'h0)
    else $error("integer format upper bits not zero");
  reserved_trig_a: assert property (state_ff == SEQ_SAMPLE && c1_ff.trigger_source[2]
    && c1_ff.trigger_source != TRIG_AUTO |-> !end_sample)
    else $error("reserved trigger ended sampling");
  auto_sample_a: assert property ($rose(sample_out) && c1_ff.trigger_source == TRIG_AUTO
    && run |-> sample_out [*2])
    else $error("internal counter ended sampling too early");
  stop_seq_a: assert property (irq_now && c1_ff.stop_after_first_irq && !wr_c1
    |=> !c1_ff.auto_sample_start)
    else $error("auto start not cleared at first interrupt");
  irq_count_a: assert property (seq_done && seq_cnt_ff != c2_ff.sequences_per_interrupt
    |=> !irq_ff)
    else $error("interrupt before the programmed sequence count");
  // The interrupt that clears auto start on the same edge is no restart case
  auto_restart_a: assert property (seq_done && c1_ff.auto_sample_start && run && !wr_c1
    && !(irq_now && c1_ff.stop_after_first_irq) |=> ##1 sample_out)
    else $error("auto start did not restart sampling");
endmodule

// ---- testbench/adc_core_model.sv ----
`timescale 1ns/100ps
// Behavioural converter core: a fixed conversion time after every start pulse
module adc_core_model #(
  parameter int CONVERT_CYCLES = 20
) (
  input wire logic clk_in,
  input wire logic convert_start_in,
  input wire logic [9:0] level_in,
  output logic convert_done_out,
  output logic [9:0] raw_result_out
);
  int count_ff = 0;
  logic [9:0] held_ff = 10'h000;
  initial begin
    convert_done_out = 1'b0;
    raw_result_out = 10'h3FF;
  end
  // Result lines only hold with the done pulse; otherwise they show the inverse
  always @(posedge clk_in) begin
    convert_done_out <= (count_ff == 1);
    if (count_ff == 1) begin
      raw_result_out <= level_in;
      held_ff <= level_in;
    end else begin
      raw_result_out <= ~held_ff;
    end
    // A new start restarts the count, as a real core would
    if (convert_start_in) begin
      count_ff <= CONVERT_CYCLES;
    end else if (count_ff != 0) begin
      count_ff <= count_ff - 1;
    end
  end
endmodule

// ---- testbench/adc_sample_convert_control_tb_top.sv ----
`timescale 1ns/100ps
module adc_sample_convert_control_tb_top;
  import adc_ctrl_pkg::*;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h00000000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic idle = 1'b0;
  logic ext_pin = 1'b0;
  logic tmr = 1'b0;
  logic charge = 1'b0;
  logic [9:0] level = 10'h2A5;
  logic [1:0] last_resp;
  wire logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, done, sample_out;
  wire logic conv_start, res_valid, irq;
  wire logic [1:0] s_bresp, s_rresp;
  wire logic [31:0] s_rdata, result_word;
  wire logic [9:0] raw;
  wire logic [3:0] slot;
  int failures = 0;
  int total_checks = 0;
  int starts_seen = 0;
  int results_seen = 0;
  int irqs_seen = 0;
  int cycles = 0;

  // Short sample window keeps the auto-convert runs brief
  adc_sample_convert_control #(.SAMPLE_CYCLES(2)) adc_sample_convert_control_inst (
    .clk_in(clk_in), .rstn_in(rstn_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(s_awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(s_wready), .s_axi_bresp_out(s_bresp), .s_axi_bvalid_out(s_bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(s_arready), .s_axi_rdata_out(s_rdata), .s_axi_rresp_out(s_rresp),
    .s_axi_rvalid_out(s_rvalid), .s_axi_rready_in(rready), .device_idle_in(idle),
    .external_interrupt_zero_in(ext_pin), .timer3_match_in(tmr),
    .charge_time_unit_in(charge), .convert_done_in(done), .raw_result_in(raw),
    .sample_out(sample_out), .convert_start_out(conv_start),
    .result_word_out(result_word), .result_slot_out(slot), .result_valid_out(res_valid),
    .irq_event_out(irq));
  adc_core_model #(.CONVERT_CYCLES(20)) adc_core_model_inst (
    .clk_in(clk_in), .convert_start_in(conv_start), .level_in(level),
    .convert_done_out(done), .raw_result_out(raw));

  always #5 clk_in = ~clk_in;
  // Event counters and the run watchdog
  always @(posedge clk_in) begin
    starts_seen <= starts_seen + int'(conv_start === 1'b1);
    results_seen <= results_seen + int'(res_valid === 1'b1);
    irqs_seen <= irqs_seen + int'(irq === 1'b1);
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      complete_run();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] expected);
    total_checks = total_checks + 1;
    if (seen !== expected) begin
      failures = failures + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Both address and data offered together; bready held until the response
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
    logic got = 1'b0;
    @(posedge clk_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!got) begin
      @(posedge clk_in);
      if (awvalid && s_awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && s_wready === 1'b1) wvalid <= 1'b0;
      if (s_bvalid === 1'b1) got = 1'b1;
    end
    last_resp = s_bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [3:0] a, output logic [31:0] d);
    logic got = 1'b0;
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got) begin
      @(posedge clk_in);
      if (arvalid && s_arready === 1'b1) arvalid <= 1'b0;
      if (s_rvalid === 1'b1) got = 1'b1;
    end
    d = s_rdata;
    last_resp = s_rresp;
    rready <= 1'b0;
  endtask

  // Bounded waits on the event counters
  task automatic wait_starts(input int target);
    for (int i = 0; i < 60 && starts_seen < target; i++) @(posedge clk_in);
  endtask
  task automatic wait_results(input int target);
    for (int i = 0; i < 60 && results_seen < target; i++) @(posedge clk_in);
  endtask

  // Control one image; flags are stop-after-irq, auto start, sample
  function automatic logic [31:0] ctl1(input logic on, input logic idle_stop,
    input logic [2:0] f, input logic [2:0] t, input logic [2:0] flags);
    ctl1 = {16'h0000, on, 1'b0, idle_stop, 2'h0, f, t, flags[2], 1'b0, flags[1:0], 1'b0};
  endfunction

  function automatic logic [31:0] fmt_word(input logic [2:0] f, input logic [9:0] r);
    case (f)
      3'h1: fmt_word = {16'h0000, {6{r[9]}}, r};
      3'h5: fmt_word = {{22{r[9]}}, r};
      3'h2, 3'h3: fmt_word = {16'h0000, r, 6'h00};
      3'h6, 3'h7: fmt_word = {r, 22'h000000};
      default: fmt_word = {22'h000000, r};
    endcase
  endfunction

  task automatic test_registers();
    logic [31:0] d;
    axi_read(CTRL_ONE_ADDR, d);
    check(d, 32'h00000000);
    axi_read(4'hC, d);
    check(32'(last_resp), 32'(RESP_SLVERR));
    axi_write(CTRL_TWO_ADDR, 32'hFFFFFFFF);
    axi_read(CTRL_TWO_ADDR, d);
    check(d, 32'h0000F43F);
    axi_write(CTRL_TWO_ADDR, 32'h00000000);
    $display("test registers finished");
  endtask

  task automatic test_formats();
    logic [31:0] d;
    logic [2:0] fm;
    int r;
    for (int f = 0; f < 8; f++) begin
      fm = f[2:0];
      // Signed layouts get a set top bit so the sign copy is visible
      level <= {fm[0], 9'h0A5};
      axi_write(CTRL_ONE_ADDR, ctl1(1'b1, 1'b0, fm, TRIG_SOFTWARE, 3'h0));
      axi_write(CTRL_ONE_ADDR, ctl1(1'b1, 1'b0, fm, TRIG_SOFTWARE, 3'h1));
      repeat (2) @(posedge clk_in);
      check(32'(sample_out), 32'h00000001);
      r = results_seen;
      axi_write(CTRL_ONE_ADDR, ctl1(1'b1, 1'b0, fm, TRIG_SOFTWARE, 3'h0));
      wait_results(r + 1);
      check(result_word, fmt_word(fm, {fm[0], 9'h0A5}));
      axi_read(CTRL_ONE_ADDR, d);
      check({30'h0, d[1:0]}, 32'h00000001);
    end
    axi_write(CTRL_ONE_ADDR, ctl1(1'b1, 1'b0, FMT_INT16, TRIG_SOFTWARE, 3'h0));
    axi_read(CTRL_ONE_ADDR, d);
    check(32'(d[0]), 32'h00000000);
    $display("test formats finished");
  endtask

  task automatic test_triggers();
    logic [2:0] trig [5] = '{TRIG_EXT_EDGE, TRIG_TIMER3, TRIG_CHARGE, TRIG_AUTO, 3'h4};
    int n;
    for (int i = 0; i < 5; i++) begin
      n = starts_seen;
      axi_write(CTRL_ONE_ADDR, ctl1(1'b1, 1'b0, FMT_INT32, trig[i], 3'h1));
      repeat (2) @(posedge clk_in);
      // The reserved code gets every trigger at once and must still ignore them
      ext_pin <= (trig[i] == TRIG_EXT_EDGE) || (i == 4);
      tmr <= (trig[i] == TRIG_TIMER3) || (i == 4);
      charge <= (trig[i] == TRIG_CHARGE) || (i == 4);
      @(posedge clk_in);
      tmr <= 1'b0;
      charge <= 1'b0;
      // The pin passes three flops and must stand two edges to be accepted
      @(posedge clk_in);
      ext_pin <= 1'b0;
      wait_starts(n + 1);
      check(32'(starts_seen - n), (i < 4) ? 32'h00000001 : 32'h00000000);
      check(32'(sample_out), (i < 4) ? 32'h00000000 : 32'h00000001);
      wait_results(results_seen + 1);
    end
    axi_write(CTRL_ONE_ADDR, 32'h00000000);
    repeat (2) @(posedge clk_in);
    check(32'(sample_out), 32'h00000000);
    $display("test triggers finished");
  endtask

  task automatic test_auto();
    logic [31:0] d;
    int n;
    int r;
    int q;
    n = starts_seen;
    r = results_seen;
    q = irqs_seen;
    axi_write(CTRL_TWO_ADDR, 32'h00000006);
    axi_write(CTRL_ONE_ADDR, ctl1(1'b1, 1'b0, FMT_INT16, TRIG_AUTO, 3'h6));
    wait_results(r + 1);
    check(32'(irqs_seen - q), 32'h00000000);
    wait_starts(n + 2);
    check(32'(starts_seen - n), 32'h00000002);
    axi_read(CTRL_ONE_ADDR, d);
    check(32'(d[0]), 32'h00000000);
    wait_results(r + 2);
    @(posedge clk_in);
    check(32'(irqs_seen - q), 32'h00000001);
    check(32'(slot), 32'h00000001);
    axi_read(CTRL_ONE_ADDR, d);
    check(32'(d[2]), 32'h00000000);
    axi_read(CTRL_TWO_ADDR, d);
    check(32'(d[7]), 32'h00000001);
    repeat (40) @(posedge clk_in);
    check(32'(starts_seen - n), 32'h00000002);
    axi_write(CTRL_ONE_ADDR, 32'h00000000);
    axi_write(CTRL_TWO_ADDR, 32'h00000000);
    $display("test auto finished");
  endtask

  task automatic test_idle();
    int n;
    axi_write(CTRL_ONE_ADDR, ctl1(1'b0, 1'b0, FMT_INT16, TRIG_SOFTWARE, 3'h1));
    repeat (2) @(posedge clk_in);
    check(32'(sample_out), 32'h00000000);
    idle <= 1'b1;
    n = starts_seen;
    axi_write(CTRL_ONE_ADDR, ctl1(1'b1, 1'b1, FMT_INT16, TRIG_AUTO, 3'h2));
    repeat (30) @(posedge clk_in);
    check(32'(starts_seen - n), 32'h00000000);
    idle <= 1'b0;
    wait_starts(n + 1);
    check(32'(starts_seen - n), 32'h00000001);
    axi_write(CTRL_ONE_ADDR, 32'h00000000);
    repeat (2) @(posedge clk_in);
    check(32'(sample_out), 32'h00000000);
    $display("test idle finished");
  endtask

  initial begin
    repeat (2) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    test_registers();
    test_formats();
    test_triggers();
    test_auto();
    test_idle();
    complete_run();
  end
endmodule
